// [hw/dmc_top.sv]
// dmc_top: two-channel word mover between program memory, data memory
// and the external memory interface, also running the boot copy.
// assumes memory ports ack a held request; the external arbiter ranks cpu first.
//
// Function
// - two independent channels, each with its own control settings
// - strap sampled after reset selects boot copy on channel zero
// - boot copies off-chip code into program memory; serial boot is alternative
// - reaches all program memory, data memory and external interface devices
// - program memory is never read, only written
// - never touches cache-configured memory or on-chip peripheral registers
// - source and destination programmed apart; fixed, step up or down
// - programmable word count; completion may raise an interrupt
// - lowest priority; starts internal access only when nothing else starts
// - internal accesses use idle cycles only, never delaying the cpu
// - cpu external requests held while a mover external access is in progress
// - each elementary move is exactly one 32-bit word
// - external interface serves mover only after pending cpu requests
`timescale 1ns/1ps
module dmc_top
    import dmc_pkg::*;
#(
    parameter int CNT_W = 16,
    parameter logic [31:0] BOOT_SRC = 32'h1000_0000,
    parameter logic [31:0] BOOT_DST = 32'h0000_0000,
    parameter logic [15:0] BOOT_WORDS = 16'h0100
) (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic boot_sel,
    input wire logic boot_serial,
    input wire logic pmem_cache_en,
    input wire logic [DMC_NUM_CH-1:0] ch_start,
    input wire logic [DMC_NUM_CH-1:0][31:0] ch_src,
    input wire logic [DMC_NUM_CH-1:0][31:0] ch_dst,
    input wire logic [DMC_NUM_CH-1:0][1:0] ch_src_mode,
    input wire logic [DMC_NUM_CH-1:0][1:0] ch_dst_mode,
    input wire logic [DMC_NUM_CH-1:0][CNT_W-1:0] ch_count,
    input wire logic [DMC_NUM_CH-1:0] ch_int_en,
    input wire logic [1:0] cpu_init,
    input wire logic [DMC_NUM_PORT-1:0] mem_ack,
    input wire logic [DMC_NUM_PORT-1:0][31:0] mem_rdata,
    output logic [DMC_NUM_PORT-1:0] mem_req_ff,
    output logic mem_we_ff,
    output logic [31:0] mem_addr_ff,
    output logic [31:0] mem_wdata_ff,
    output logic emif_hold_cpu_ff,
    output logic [DMC_NUM_CH-1:0] ch_busy_ff,
    output logic [DMC_NUM_CH-1:0] ch_irq_ff,
    output logic [DMC_NUM_CH-1:0] ch_err_ff,
    output logic boot_done_ff
);
    if (CNT_W < 2 || CNT_W > 32) begin : g_chk
        $error("CNT_W must lie between 2 and 32");
    end

    dmc_state_type state_ff;
    logic sel_ff;
    logic [1:0] rport_ff;
    logic [1:0] wport_ff;
    logic boot_arm_ff;
    logic boot_run_ff;
    logic [DMC_NUM_CH-1:0] int_en_ff;
    logic [DMC_NUM_CH-1:0][31:0] src_q;
    logic [DMC_NUM_CH-1:0][31:0] dst_q;
    logic [DMC_NUM_CH-1:0] act_q;
    logic [DMC_NUM_CH-1:0] done_q;
    logic [DMC_NUM_CH-1:0] load;
    logic [DMC_NUM_CH-1:0] step;
    logic [DMC_NUM_CH-1:0] abort;
    logic boot_go;
    logic pick;
    dmc_region_type src_rg;
    dmc_region_type dst_rg;
    logic legal;
    logic [1:0] port_now;
    logic port_free;

    // strap caught one cycle after reset release
    assign boot_go = boot_arm_ff && boot_sel && !boot_serial;

    // one counter and address pair per channel
    for (genvar i = 0; i < DMC_NUM_CH; i++) begin : g_ch
        logic bt;
        assign bt = (i == 0) && boot_go;
        assign load[i] = ch_start[i] || bt;
        dmc_chan #(.CNT_W(CNT_W)) u_chan (
            .core_clk(core_clk),
            .sys_rst(sys_rst),
            .load(load[i]),
            .load_src(bt ? BOOT_SRC : ch_src[i]),
            .load_dst(bt ? BOOT_DST : ch_dst[i]),
            .load_src_mode(bt ? DMC_AM_INC : ch_src_mode[i]),
            .load_dst_mode(bt ? DMC_AM_INC : ch_dst_mode[i]),
            .load_count(bt ? CNT_W'(BOOT_WORDS) : ch_count[i]),
            .step(step[i]),
            .abort(abort[i]),
            .src_ff(src_q[i]),
            .dst_ff(dst_q[i]),
            .active_ff(act_q[i]),
            .done_ff(done_q[i])
        );
        assign step[i] = (state_ff == DMC_ST_WRITE) && (sel_ff == 1'(i))
            && mem_req_ff[wport_ff] && mem_ack[wport_ff];
        assign abort[i] = (state_ff == DMC_ST_IDLE) && (pick == 1'(i))
            && act_q[i] && !legal && !load[i];
    end

    assign pick = !act_q[0];
    assign src_rg = dmc_region(src_q[pick]);
    assign dst_rg = dmc_region(dst_q[pick]);
    // program memory never a source; no cache, no peripheral registers
    // any data memory or external location, program memory as target
    assign legal = (src_rg == DMC_RG_DMEM_R || src_rg == DMC_RG_EMIF_R)
        && (dst_rg == DMC_RG_DMEM_R || dst_rg == DMC_RG_EMIF_R
            || (dst_rg == DMC_RG_PMEM_R && !pmem_cache_en));

    assign port_now = (state_ff == DMC_ST_WRITE) ? wport_ff : rport_ff;
    // internal access only in a cycle nobody else starts one
    assign port_free = (port_now == 2'(DMC_EMIF)) ? 1'b1 : !cpu_init[port_now[0]];

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            state_ff <= DMC_ST_IDLE;
            sel_ff <= DMC_RST_LOW;
            rport_ff <= 2'h0;
            wport_ff <= 2'h0;
        end else begin
            case (state_ff)
                DMC_ST_IDLE: begin
                    if ((|act_q) && legal && !(|load)) begin
                        sel_ff <= pick;
                        rport_ff <= src_rg;
                        wport_ff <= dst_rg;
                        state_ff <= DMC_ST_READ;
                    end
                end
                DMC_ST_READ: begin
                    if (mem_req_ff[rport_ff] && mem_ack[rport_ff]) begin
                        state_ff <= DMC_ST_WRITE;
                    end
                end
                DMC_ST_WRITE: begin
                    if (mem_req_ff[wport_ff] && mem_ack[wport_ff]) begin
                        state_ff <= DMC_ST_IDLE;
                    end
                end
                default: state_ff <= DMC_ST_IDLE;
            endcase
        end
    end

    // one full word read, then the same word written
    // external request waits for the arbiter's ack, cpu ranks above
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            mem_req_ff <= '0;
            mem_we_ff <= DMC_RST_LOW;
            mem_addr_ff <= DMC_RST_WORD;
            mem_wdata_ff <= DMC_RST_WORD;
        end else if (state_ff != DMC_ST_IDLE) begin
            if (mem_req_ff[port_now]) begin
                if (mem_ack[port_now]) begin
                    mem_req_ff <= '0;
                    if (state_ff == DMC_ST_READ) begin
                        mem_wdata_ff <= mem_rdata[port_now];
                    end
                end
            end else if (port_free) begin
                mem_req_ff[port_now] <= 1'b1;
                mem_we_ff <= (state_ff == DMC_ST_WRITE);
                mem_addr_ff <= (state_ff == DMC_ST_WRITE) ? dst_q[sel_ff] : src_q[sel_ff];
            end
        end
    end

    // cpu held while an external access of ours runs
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            emif_hold_cpu_ff <= DMC_RST_LOW;
        end else if (state_ff != DMC_ST_IDLE && port_now == 2'(DMC_EMIF)) begin
            emif_hold_cpu_ff <= mem_req_ff[DMC_EMIF] ? !mem_ack[DMC_EMIF] : 1'b1;
        end else begin
            emif_hold_cpu_ff <= DMC_RST_LOW;
        end
    end

    // completion interrupt, enable latched at start
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            int_en_ff <= '0;
            ch_irq_ff <= '0;
            ch_busy_ff <= '0;
            ch_err_ff <= '0;
        end else begin
            for (int i = 0; i < DMC_NUM_CH; i++) begin
                if (load[i]) begin
                    int_en_ff[i] <= (i == 0 && boot_go) ? 1'b0 : ch_int_en[i];
                end
                ch_err_ff[i] <= load[i] ? 1'b0 : (ch_err_ff[i] || abort[i]);
            end
            ch_irq_ff <= done_q & int_en_ff;
            ch_busy_ff <= act_q;
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            boot_arm_ff <= DMC_RST_ARM;
            boot_run_ff <= DMC_RST_LOW;
            boot_done_ff <= DMC_RST_LOW;
        end else begin
            boot_arm_ff <= DMC_RST_LOW;
            if (boot_go) begin
                boot_run_ff <= 1'b1;
            end else if (boot_arm_ff) begin
                boot_done_ff <= 1'b1;
            end else if (boot_run_ff && (done_q[0] || abort[0])) begin
                boot_run_ff <= DMC_RST_LOW;
                boot_done_ff <= 1'b1;
            end
        end
    end

    a_no_pmem_rd: assert property (@(posedge core_clk) disable iff (sys_rst)
        mem_req_ff[DMC_PMEM] |-> mem_we_ff)
        else $error("read request on program memory");
    // no cache and no peripheral registers
    a_cache_block: assert property (@(posedge core_clk) disable iff (sys_rst)
        $rose(mem_req_ff[DMC_PMEM]) |-> $past(!pmem_cache_en))
        else $error("program memory touched while cached");
    a_periph_block: assert property (@(posedge core_clk) disable iff (sys_rst)
        (|mem_req_ff) |-> mem_addr_ff[DMC_RG_MSB:DMC_RG_LSB] != DMC_NIB_PERIPH)
        else $error("peripheral register region accessed");
    a_idle_steal: assert property (@(posedge core_clk) disable iff (sys_rst)
        ($rose(mem_req_ff[DMC_DMEM]) |-> !$past(cpu_init[DMC_DMEM]))
        and ($rose(mem_req_ff[DMC_PMEM]) |-> !$past(cpu_init[DMC_PMEM])))
        else $error("internal access started beside a cpu access");
    a_cpu_hold: assert property (@(posedge core_clk) disable iff (sys_rst)
        (mem_req_ff[DMC_EMIF] && !mem_ack[DMC_EMIF])
            |=> mem_req_ff[DMC_EMIF] && emif_hold_cpu_ff)
        else $error("external request dropped or cpu not held");
    // word read is the word written
    a_word_move: assert property (@(posedge core_clk) disable iff (sys_rst)
        (state_ff == DMC_ST_READ && mem_req_ff[rport_ff] && mem_ack[rport_ff])
            |=> state_ff == DMC_ST_WRITE && mem_wdata_ff == $past(mem_rdata[rport_ff]))
        else $error("written word differs from read word");
    a_fixed_prio: assert property (@(posedge core_clk) disable iff (sys_rst)
        (state_ff == DMC_ST_IDLE && act_q == 2'b11 && legal && !(|load))
            |=> state_ff == DMC_ST_READ && sel_ff == 1'b0)
        else $error("channel one served before channel zero");
    a_irq_done: assert property (@(posedge core_clk) disable iff (sys_rst)
        (done_q[1] && int_en_ff[1]) |=> ch_irq_ff[1])
        else $error("completion interrupt missing");
    // strap starts boot on channel zero
    a_boot_start: assert property (@(posedge core_clk) disable iff (sys_rst)
        boot_go |=> boot_run_ff && (act_q[0] || done_q[0]))
        else $error("boot copy not started");
endmodule // dmc_top

// [inc/dmc_pkg.sv]
// dmc_pkg: constants and types for the two-channel word mover.
// assumes one core clock and a synchronous active-high reset.
package dmc_pkg;
    localparam int DMC_ADDR_W = 32;
    localparam int DMC_DATA_W = 32;
    localparam int DMC_NUM_CH = 2;
    // address step of one word move, in bytes
    localparam logic [31:0] DMC_WORD_BYTES = 32'h0000_0004;
    // region decode on the top address nibble
    localparam int DMC_RG_MSB = 31;
    localparam int DMC_RG_LSB = 28;
    localparam logic [3:0] DMC_NIB_PMEM = 4'h0;
    localparam logic [3:0] DMC_NIB_PERIPH = 4'h4;
    localparam logic [3:0] DMC_NIB_DMEM = 4'h8;
    // index of each target port on the memory side
    localparam int DMC_PMEM = 0;
    localparam int DMC_DMEM = 1;
    localparam int DMC_EMIF = 2;
    localparam int DMC_NUM_PORT = 3;
    // reset values
    localparam logic DMC_RST_ARM = 1'b1;
    localparam logic DMC_RST_LOW = 1'b0;
    localparam logic [31:0] DMC_RST_WORD = 32'h0000_0000;

    typedef enum logic [1:0] {
        DMC_RG_PMEM_R = 2'b00,
        DMC_RG_DMEM_R = 2'b01,
        DMC_RG_EMIF_R = 2'b10,
        DMC_RG_PERIPH_R = 2'b11
    } dmc_region_type;

    typedef enum logic [1:0] {
        DMC_AM_FIXED = 2'b00,
        DMC_AM_INC = 2'b01,
        DMC_AM_DEC = 2'b10
    } dmc_amode_type;

    typedef enum logic [1:0] {
        DMC_ST_IDLE = 2'b00,
        DMC_ST_READ = 2'b01,
        DMC_ST_WRITE = 2'b10
    } dmc_state_type;

    function automatic dmc_region_type dmc_region(input logic [31:0] addr);
        logic [3:0] nib;
        nib = addr[DMC_RG_MSB:DMC_RG_LSB];
        if (nib == DMC_NIB_PMEM) return DMC_RG_PMEM_R;
        else if (nib == DMC_NIB_DMEM) return DMC_RG_DMEM_R;
        else if (nib == DMC_NIB_PERIPH) return DMC_RG_PERIPH_R;
        else return DMC_RG_EMIF_R;
    endfunction
endpackage

// [hw/dmc_chan.sv]
// dmc_chan: one channel's address generators and word counter.
// assumes the engine pulses step after each finished word move.
`timescale 1ns/1ps
module dmc_chan
    import dmc_pkg::*;
#(
    parameter int CNT_W = 16
) (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic load,
    input wire logic [31:0] load_src,
    input wire logic [31:0] load_dst,
    input wire logic [1:0] load_src_mode,
    input wire logic [1:0] load_dst_mode,
    input wire logic [CNT_W-1:0] load_count,
    input wire logic step,
    input wire logic abort,
    output logic [31:0] src_ff,
    output logic [31:0] dst_ff,
    output logic active_ff,
    output logic done_ff
);
    logic [CNT_W-1:0] remain_ff;
    logic [1:0] smode_ff;
    logic [1:0] dmode_ff;

    function automatic logic [31:0] nxt_addr(input logic [31:0] a, input logic [1:0] m);
        if (m == DMC_AM_INC) return a + DMC_WORD_BYTES;
        else if (m == DMC_AM_DEC) return a - DMC_WORD_BYTES;
        else return a;
    endfunction

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            src_ff <= DMC_RST_WORD;
            dst_ff <= DMC_RST_WORD;
            smode_ff <= DMC_AM_FIXED;
            dmode_ff <= DMC_AM_FIXED;
        end else if (load) begin
            src_ff <= load_src;
            dst_ff <= load_dst;
            smode_ff <= load_src_mode;
            dmode_ff <= load_dst_mode;
        end else if (step) begin
            src_ff <= nxt_addr(src_ff, smode_ff);
            dst_ff <= nxt_addr(dst_ff, dmode_ff);
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            remain_ff <= '0;
            active_ff <= DMC_RST_LOW;
            done_ff <= DMC_RST_LOW;
        end else begin
            done_ff <= DMC_RST_LOW;
            if (load) begin
                remain_ff <= load_count;
                active_ff <= (load_count != '0);
                done_ff <= (load_count == '0);
            end else if (abort) begin
                active_ff <= DMC_RST_LOW;
            end else if (step) begin
                remain_ff <= remain_ff - 1'b1;
                if (remain_ff == {{(CNT_W-1){1'b0}}, 1'b1}) begin
                    active_ff <= DMC_RST_LOW;
                    done_ff <= 1'b1;
                end
            end
        end
    end

    a_step_inc: assert property (@(posedge core_clk) disable iff (sys_rst)
        ($past(step) && !$past(load) && $past(smode_ff) == DMC_AM_INC)
            |-> src_ff == $past(src_ff) + DMC_WORD_BYTES)
        else $error("source address did not step up by one word");
    a_count_end: assert property (@(posedge core_clk) disable iff (sys_rst)
        (step && !load && !abort && remain_ff == {{(CNT_W-1){1'b0}}, 1'b1})
            |=> done_ff && !active_ff)
        else $error("channel did not finish on last word");
endmodule // dmc_chan

// [verification/dmc_mem_model.sv]
// dmc_mem_model: memory-side partner with three acking ports and rule monitors.
// assumes the mover holds each request until its ack and drops it after.
`timescale 1ns/1ps
module dmc_mem_model
    import dmc_pkg::*;
(
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic [DMC_NUM_PORT-1:0] mem_req_ff,
    input wire logic mem_we_ff,
    input wire logic [31:0] mem_addr_ff,
    input wire logic [31:0] mem_wdata_ff,
    input wire logic [1:0] cpu_init,
    input wire logic emif_hold_cpu_ff,
    input wire logic [3:0] lat,
    output logic [DMC_NUM_PORT-1:0] mem_ack = '0,
    output logic [DMC_NUM_PORT-1:0][31:0] mem_rdata = '0
);
    logic [31:0] mem [DMC_NUM_PORT][logic [31:0]];
    logic [3:0] wait_cnt [DMC_NUM_PORT] = '{default: 4'h0};
    logic [DMC_NUM_PORT-1:0] req_q = '0;
    logic [1:0] init_q = 2'h0;
    int reads [DMC_NUM_PORT] = '{default: 0};
    int writes [DMC_NUM_PORT] = '{default: 0};
    int viol = 0;

    // unwritten words read back as a pattern of their address
    function automatic logic [31:0] pat(input logic [31:0] a);
        return {a[15:0] ^ 16'hC3A5, a[31:16]};
    endfunction

    function automatic logic [31:0] peek(input int p, input logic [31:0] a);
        return mem[p].exists(a) ? mem[p][a] : pat(a);
    endfunction

    always @(posedge core_clk) begin
        req_q <= mem_req_ff;
        init_q <= cpu_init;
        for (int p = 0; p < DMC_NUM_PORT; p++) begin
            mem_ack[p] <= 1'b0;
            // released read bus flips every cycle
            mem_rdata[p] <= ~mem_rdata[p];
            if (sys_rst || !mem_req_ff[p] || mem_ack[p]) begin
                wait_cnt[p] <= 4'h0;
            end else if (wait_cnt[p] < lat) begin
                wait_cnt[p] <= wait_cnt[p] + 4'h1;
            end else begin
                mem_ack[p] <= 1'b1;
                if (mem_we_ff) begin
                    mem[p][mem_addr_ff] = mem_wdata_ff;
                    writes[p]++;
                end else begin
                    mem_rdata[p] <= peek(p, mem_addr_ff);
                    reads[p]++;
                end
            end
        end
        if (mem_req_ff[DMC_PMEM] && !mem_we_ff) viol++;
        if (mem_req_ff != '0 && mem_addr_ff[31:28] == DMC_NIB_PERIPH) viol++;
        if ((mem_req_ff[1:0] & ~req_q[1:0] & init_q) != 2'h0) viol++;
        if (mem_req_ff[DMC_EMIF] && !emif_hold_cpu_ff) viol++;
        if (!$onehot0(mem_req_ff)) viol++;
    end
endmodule // dmc_mem_model

// [verification/two_channel_dma_controller_tb.sv]
// two_channel_dma_controller_tb: self-checking bench for dmc_top.
// assumes dmc_mem_model answers on the memory ports.
`timescale 1ns/1ps
module two_channel_dma_controller_tb
    import dmc_pkg::*;
;
    localparam int CW = 8;
    localparam logic [31:0] BSRC = 32'h1000_0000;
    localparam logic [31:0] BDST = 32'h0000_0040;
    localparam logic [15:0] BWORDS = 16'h0004;
    localparam logic [1:0] FX = DMC_AM_FIXED;
    localparam logic [1:0] AI = DMC_AM_INC;
    localparam logic [1:0] AD = DMC_AM_DEC;
    typedef struct {
        int ch;
        logic [31:0] src;
        logic [31:0] dst;
        logic [1:0] sm;
        logic [1:0] dm;
        int n;
        logic ie;
        logic cache;
        logic [3:0] lat;
        logic err;
    } dmc_row_type;
    dmc_row_type rows [9] = '{
        '{0, 32'h8000_0100, 32'h2000_0000, AI, AI, 4, 1, 0, 4'h0, 0},
        '{1, 32'h3000_0040, 32'h8000_0200, AD, AI, 3, 1, 0, 4'h2, 0},
        '{0, 32'h8000_0300, 32'h0000_0010, FX, AD, 2, 0, 0, 4'h1, 0},
        '{1, 32'h2000_0100, 32'h8000_0400, AI, FX, 3, 1, 0, 4'h3, 0},
        '{0, 32'h8000_0700, 32'h8000_0800, AD, AI, 2, 1, 0, 4'h0, 0},
        '{1, 32'h8000_0900, 32'h2000_0200, AI, AI, 0, 1, 0, 4'h0, 0},
        '{0, 32'h0000_0000, 32'h8000_0500, AI, AI, 2, 1, 0, 4'h0, 1},
        '{1, 32'h8000_0600, 32'h4000_0000, AI, AI, 2, 1, 0, 4'h0, 1},
        '{0, 32'h8000_0D00, 32'h0000_0100, AI, AI, 1, 1, 1, 4'h0, 1}};
    logic core_clk, sys_rst, boot_sel, boot_serial, pmem_cache_en, emif_hold_cpu_ff;
    logic mem_we_ff, boot_done_ff, any_out;
    logic [1:0] ch_start, ch_int_en, cpu_init, ch_busy_ff, ch_irq_ff, ch_err_ff;
    logic [1:0][31:0] ch_src, ch_dst;
    logic [1:0][1:0] ch_src_mode, ch_dst_mode;
    logic [1:0][CW-1:0] ch_count;
    logic [2:0] mem_ack, mem_req_ff;
    logic [2:0][31:0] mem_rdata;
    logic [31:0] mem_addr_ff, mem_wdata_ff;
    logic [3:0] lat;
    int mismatches = 0;
    int samples_checked = 0;
    int cycles = 0;
    int w0;
    int w1;
    assign any_out = |{mem_req_ff, mem_we_ff, mem_addr_ff, mem_wdata_ff, emif_hold_cpu_ff,
                       ch_busy_ff, ch_irq_ff, ch_err_ff, boot_done_ff};

    dmc_top #(.CNT_W(CW), .BOOT_SRC(BSRC), .BOOT_DST(BDST), .BOOT_WORDS(BWORDS)) dut (
        .core_clk(core_clk), .sys_rst(sys_rst), .boot_sel(boot_sel),
        .boot_serial(boot_serial), .pmem_cache_en(pmem_cache_en), .ch_start(ch_start),
        .ch_src(ch_src), .ch_dst(ch_dst), .ch_src_mode(ch_src_mode),
        .ch_dst_mode(ch_dst_mode), .ch_count(ch_count), .ch_int_en(ch_int_en),
        .cpu_init(cpu_init), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
        .mem_req_ff(mem_req_ff), .mem_we_ff(mem_we_ff), .mem_addr_ff(mem_addr_ff),
        .mem_wdata_ff(mem_wdata_ff), .emif_hold_cpu_ff(emif_hold_cpu_ff),
        .ch_busy_ff(ch_busy_ff), .ch_irq_ff(ch_irq_ff), .ch_err_ff(ch_err_ff),
        .boot_done_ff(boot_done_ff));
    dmc_mem_model model (
        .core_clk(core_clk), .sys_rst(sys_rst), .mem_req_ff(mem_req_ff),
        .mem_we_ff(mem_we_ff), .mem_addr_ff(mem_addr_ff), .mem_wdata_ff(mem_wdata_ff),
        .cpu_init(cpu_init), .emif_hold_cpu_ff(emif_hold_cpu_ff), .lat(lat),
        .mem_ack(mem_ack), .mem_rdata(mem_rdata));

    task automatic chk(input logic [31:0] seen, input logic [31:0] want);
        samples_checked++;
        if (seen !== want) begin
            mismatches++;
            $display("mismatch t=%0t seen=%h want=%h", $time, seen, want);
        end
    endtask

    task automatic end_of_test();
        chk(32'(model.viol), 32'h0);
        $display("checked %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    function automatic logic [31:0] step(input logic [31:0] a, input logic [1:0] m);
        return m == AI ? a + DMC_WORD_BYTES : (m == AD ? a - DMC_WORD_BYTES : a);
    endfunction

    function automatic int port_of(input logic [31:0] a);
        return a[31:28] == DMC_NIB_PMEM ? DMC_PMEM
            : (a[31:28] == DMC_NIB_DMEM ? DMC_DMEM : DMC_EMIF);
    endfunction

    function automatic int total(input bit wr);
        int t = 0;
        for (int p = 0; p < DMC_NUM_PORT; p++) t += wr ? model.writes[p] : model.reads[p];
        return t;
    endfunction

    task automatic wait_idle();
        for (int k = 0; k < 400; k++) begin
            @(posedge core_clk);
            #1;
            if (k > 3 && ch_busy_ff === 2'b00) break;
        end
    endtask

    task automatic run_row(input dmc_row_type r);
        logic [31:0] exp_v [logic [31:0]];
        logic [31:0] s = r.src;
        logic [31:0] d = r.dst;
        int r0 = total(1'b0);
        int wr0 = total(1'b1);
        int irq_n = 0;
        int quiet = 0;
        for (int k = 0; k < (r.err ? 0 : r.n); k++) begin
            exp_v[d] = model.pat(s);
            s = step(s, r.sm);
            d = step(d, r.dm);
        end
        @(posedge core_clk);
        lat <= r.lat;
        pmem_cache_en <= r.cache;
        ch_start[r.ch] <= 1'b1;
        ch_src[r.ch] <= r.src;
        ch_dst[r.ch] <= r.dst;
        ch_src_mode[r.ch] <= r.sm;
        ch_dst_mode[r.ch] <= r.dm;
        ch_count[r.ch] <= CW'(r.n);
        ch_int_en[r.ch] <= r.ie;
        @(posedge core_clk);
        ch_start <= 2'b00;
        for (int k = 0; k < 400 && quiet < 6; k++) begin
            @(posedge core_clk);
            #1;
            irq_n += int'(ch_irq_ff[r.ch]);
            quiet = (ch_busy_ff[r.ch] === 1'b0) ? quiet + 1 : 0;
            if (k == 1) chk(32'(ch_busy_ff[r.ch]), 32'(r.n != 0 && !r.err));
        end
        chk(32'(total(1'b1) - wr0), 32'(r.err ? 0 : r.n));
        chk(32'(total(1'b0) - r0), 32'(r.err ? 0 : r.n));
        chk(32'(ch_err_ff[r.ch]), 32'(r.err));
        chk(32'(irq_n), 32'(r.ie && !r.err));
        foreach (exp_v[a]) chk(model.peek(port_of(a), a), exp_v[a]);
    endtask

    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end

    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 6000) begin
            mismatches++;
            end_of_test();
        end
    end

    initial begin
        {sys_rst, boot_sel, boot_serial, pmem_cache_en} = 4'b1100;
        {ch_start, ch_int_en, cpu_init, ch_src, ch_dst} = '0;
        {ch_src_mode, ch_dst_mode, ch_count} = '0;
        lat = 4'h1;
        repeat (10) @(posedge core_clk);
        #1 chk(32'(any_out), 32'h0);
        repeat (2) @(posedge core_clk);
        sys_rst <= 1'b0;
        for (int k = 0; k < 400 && boot_done_ff !== 1'b1; k++) @(posedge core_clk);
        #1 chk(32'(boot_done_ff), 32'h1);
        chk(32'(model.writes[DMC_PMEM]), 32'(BWORDS));
        for (int k = 0; k < int'(BWORDS); k++) begin
            chk(model.peek(DMC_PMEM, BDST + 4 * k), model.pat(BSRC + 4 * k));
        end
        @(posedge core_clk);
        boot_sel <= 1'b0;
        foreach (rows[i]) run_row(rows[i]);
        // both channels in one cycle
        w0 = total(1'b1);
        @(posedge core_clk);
        {pmem_cache_en, lat, ch_int_en} <= '0;
        ch_start <= 2'b11;
        ch_src <= {32'h2000_0400, 32'h8000_0A00};
        ch_dst <= {32'h8000_0B00, 32'h2000_0300};
        {ch_src_mode, ch_dst_mode} <= {4{AI}};
        ch_count <= {2{CW'(2)}};
        @(posedge core_clk);
        ch_start <= 2'b00;
        for (int k = 0; k < 20 && mem_req_ff === 3'b000; k++) @(posedge core_clk);
        #1 chk(mem_addr_ff, 32'h8000_0A00);
        wait_idle();
        chk(32'(total(1'b1) - w0), 32'h4);
        // cpu keeps starting dmem and pmem accesses, then pmem ones only
        w0 = total(1'b0);
        w1 = model.writes[DMC_PMEM];
        @(posedge core_clk);
        cpu_init <= 2'b11;
        ch_start <= 2'b01;
        ch_src[0] <= 32'h8000_0C00;
        ch_dst[0] <= 32'h0000_0080;
        ch_count[0] <= CW'(1);
        @(posedge core_clk);
        ch_start <= 2'b00;
        repeat (20) @(posedge core_clk);
        #1 chk(32'(total(1'b0) - w0), 32'h0);
        @(posedge core_clk);
        cpu_init <= 2'b01;
        repeat (20) @(posedge core_clk);
        #1 chk(32'(total(1'b0) - w0), 32'h1);
        chk(32'(model.writes[DMC_PMEM] - w1), 32'h0);
        @(posedge core_clk);
        cpu_init <= 2'b00;
        wait_idle();
        chk(32'(total(1'b0) - w0), 32'h1);
        chk(32'(model.writes[DMC_PMEM] - w1), 32'h1);
        // reset mid-transfer, serial boot strap
        @(posedge core_clk);
        {ch_start, lat, boot_sel, boot_serial} <= {2'b01, 4'h3, 2'b11};
        ch_count[0] <= CW'(40);
        @(posedge core_clk);
        ch_start <= 2'b00;
        repeat (30) @(posedge core_clk);
        sys_rst <= 1'b1;
        repeat (3) @(posedge core_clk);
        #1 chk(32'(any_out), 32'h0);
        w0 = total(1'b1);
        @(posedge core_clk);
        sys_rst <= 1'b0;
        repeat (30) @(posedge core_clk);
        #1 chk(32'(boot_done_ff), 32'h1);
        chk(32'(total(1'b1) - w0), 32'h0);
        chk(32'(ch_busy_ff), 32'h0);
        end_of_test();
    end
endmodule // two_channel_dma_controller_tb
